// *** rtl/pin_sync.v ***
// two flip-flop synchroniser for a group of level inputs
// assumes inputs are asynchronous to clock
`default_nettype none
module pin_sync #(
	parameter WIDTH = 8
) (
	input  wire             clock,
	input  wire             srst,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	always @(posedge clock) begin
		if (srst) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end
	assign sync_out = sync_reg;
endmodule // pin_sync
`default_nettype wire

// *** rtl/poll_sequencer.v ***
// controller-side command sequencer: serial poll, parallel poll, poll configure
// assumes a byte command port that the bus engine accepts on cmd_ready
`include "poll_status_regs.vh"
`default_nettype none
module poll_sequencer (
	// clock and reset
	input  wire       clock,
	input  wire       srst,
	// control
	input  wire       is_controller,
	input  wire       start_serial_poll_routine,
	input  wire       start_parallel_poll_routine,
	input  wire       start_ppcfg,
	input  wire [7:0] arg,
	// bus command port
	output reg        cmd_valid,
	output reg  [7:0] cmd_byte,
	input  wire       cmd_ready,
	output reg        serial_poll_routine_listen,
	input  wire       rx_valid,
	input  wire [7:0] rx_byte,
	output reg        parallel_poll_routine_sample,
	input  wire [7:0] dio_sync,
	// results
	output reg  [7:0] result_reg,
	output wire       busy,
	output reg        done_pulse
);
	localparam ST_IDLE = 3'h0;
	localparam ST_SEND = 3'h1;
	localparam ST_RECV = 3'h2;
	localparam ST_PP   = 3'h3;

	reg [2:0] state_reg;
	reg [2:0] step_reg;
	reg [1:0] kind_reg;
	reg [7:0] arg_reg;
	reg [7:0] next_cmd;

	assign busy = (state_reg != ST_IDLE);

	// serial poll: talk address, enable, disable, untalk; configure: listen address, configure, configuration byte, unlisten
	always @* begin
		next_cmd = `GPIB_UNT;
		if (kind_reg == 2'h1) begin
			case (step_reg)
				3'h0: next_cmd = `GPIB_TAG_TALK | {3'h0, arg_reg[4:0]};
				3'h1: next_cmd = `GPIB_SPE;
				3'h2: next_cmd = `GPIB_SPD;
				default: next_cmd = `GPIB_UNT;
			endcase
		end else begin
			case (step_reg)
				3'h0: next_cmd = `GPIB_TAG_LISTEN | {3'h0, arg_reg[4:0]};
				3'h1: next_cmd = `GPIB_PPC;
				3'h2: next_cmd = arg_reg;
				default: next_cmd = `GPIB_UNL;
			endcase
		end
	end

	always @(posedge clock) begin
		if (srst) begin
			state_reg    <= ST_IDLE;
			step_reg     <= 3'h0;
			kind_reg     <= 2'h0;
			arg_reg      <= 8'h00;
			cmd_valid    <= 1'b0;
			cmd_byte     <= 8'h00;
			serial_poll_routine_listen <= 1'b0;
			parallel_poll_routine_sample <= 1'b0;
			result_reg   <= 8'h00;
			done_pulse   <= 1'b0;
		end else begin
			done_pulse   <= 1'b0;
			parallel_poll_routine_sample <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (is_controller && start_serial_poll_routine) begin
						kind_reg  <= 2'h1;
						arg_reg   <= arg;
						step_reg  <= 3'h0;
						state_reg <= ST_SEND;
					end else if (is_controller && start_parallel_poll_routine) begin
						parallel_poll_routine_sample <= 1'b1;
						state_reg    <= ST_PP;
					end else if (is_controller && start_ppcfg) begin
						kind_reg  <= 2'h2;
						arg_reg   <= arg;
						step_reg  <= 3'h0;
						state_reg <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (!cmd_valid) begin
						cmd_valid <= 1'b1;
						cmd_byte  <= next_cmd;
					end else if (cmd_ready) begin
						cmd_valid <= 1'b0;
						step_reg  <= step_reg + 3'h1;
						if (kind_reg == 2'h1 && step_reg == 3'h1) begin
							serial_poll_routine_listen <= 1'b1;
							state_reg    <= ST_RECV;
						end else if (step_reg == 3'h3) begin
							done_pulse <= 1'b1;
							state_reg  <= ST_IDLE;
						end
					end
				end
				ST_RECV: begin
					// exactly one response byte taken
					if (rx_valid) begin
						result_reg   <= rx_byte;
						serial_poll_routine_listen <= 1'b0;
						state_reg    <= ST_SEND;
					end
				end
				ST_PP: begin
					// all eight lines sampled together, one per device or group
					result_reg <= dio_sync;
					done_pulse <= 1'b1;
					state_reg  <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule // poll_sequencer
`default_nettype wire

// *** rtl/poll_status.v ***
// poll, service request and interrupt status block with an AHB-Lite register slave
// assumes a bus engine that reports talker/listener states and received commands
// as single-cycle pulses on the same clock; bus line inputs are asynchronous
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`include "poll_status_regs.vh"
`default_nettype none
module poll_status #(
	parameter DMA_CHANNELS = 3
) (
	// clock and reset
	input  wire                    clock,
	input  wire                    srst,
	// ahb-lite slave
	input  wire                    hsel,
	input  wire [7:0]              haddr,
	input  wire [1:0]              htrans,
	input  wire                    hwrite,
	input  wire [2:0]              hsize,
	input  wire [31:0]             hwdata,
	input  wire                    hready,
	output wire                    hreadyout,
	output wire                    hresp,
	output reg  [31:0]             hrdata,
	// bus lines, asynchronous
	input  wire                    srq_in,
	input  wire [7:0]              dio_in,
	output wire                    srq_out,
	output wire                    srq_oe,
	// bus engine, same clock
	input  wire                    talk_addressed_bit,
	input  wire                    listen_addressed_bit,
	input  wire                    remote_state,
	input  wire                    lockout_state,
	input  wire                    trigger_rcvd,
	input  wire                    clear_rcvd,
	input  wire                    byte_in_event,
	input  wire                    byte_out_event,
	input  wire                    serial_polled,
	output wire                    cmd_valid,
	output wire [7:0]              cmd_byte,
	input  wire                    cmd_ready,
	output wire                    serial_poll_routine_listen,
	input  wire                    rx_valid,
	input  wire [7:0]              rx_byte,
	output wire                    parallel_poll_routine_sample,
	output reg  [7:0]              poll_response,
	// dma
	input  wire [DMA_CHANNELS-1:0] dma_tc_event,
	input  wire                    dma_want,
	input  wire                    dma_ack,
	output wire                    dma_request_line,
	// interrupt
	output wire                    irq
);
	wire [8:0] sync_out;
	wire       srq_line;
	wire [7:0] dio_sync;

	pin_sync #(
		.WIDTH(9)
	) u_sync (
		.clock   (clock),
		.srst    (srst),
		.async_in({srq_in, dio_in}),
		.sync_out(sync_out)
	);
	assign srq_line = sync_out[8];
	assign dio_sync = sync_out[7:0];

	// ahb address phase capture
	reg        wr_pend_reg;
	reg        rd_pend_reg;
	reg  [7:0] addr_reg;
	wire       take;

	assign take      = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always @(posedge clock) begin
		if (srst) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
		end else begin
			wr_pend_reg <= take && hwrite;
			rd_pend_reg <= take && !hwrite;
			if (take) begin
				addr_reg <= {haddr[7:2], 2'b00};
			end
		end
	end

	wire wr_ctrl   = wr_pend_reg && (addr_reg == `ADDR_CTRL);
	wire wr_rsp    = wr_pend_reg && (addr_reg == `ADDR_POLL_RSP);
	wire wr_cmd    = wr_pend_reg && (addr_reg == `ADDR_CMD);
	wire wr_mask1  = wr_pend_reg && (addr_reg == `ADDR_IMASK1);
	wire wr_mask2  = wr_pend_reg && (addr_reg == `ADDR_IMASK2);
	// read data is registered on the address phase edge, so clearing there loses nothing
	wire rd_stat1  = take && !hwrite && ({haddr[7:2], 2'b00} == `ADDR_ISTAT1);
	wire rd_stat2  = take && !hwrite && ({haddr[7:2], 2'b00} == `ADDR_ISTAT2);
	wire rd_bus    = take && !hwrite && ({haddr[7:2], 2'b00} == `ADDR_BUS_STAT);
	wire rd_dma    = take && !hwrite && ({haddr[7:2], 2'b00} == `ADDR_DMA_STAT);

	// control registers
	reg       cic_reg;
	reg       rqs_reg;
	reg [4:0] mask1_reg;
	reg [2:0] mask2_reg;

	always @(posedge clock) begin
		if (srst) begin
			cic_reg       <= 1'b0;
			rqs_reg       <= 1'b0;
			poll_response <= `RST_BYTE;
			mask1_reg     <= 5'h00;
			mask2_reg     <= 3'h0;
		end else begin
			if (wr_ctrl) begin
				cic_reg <= hwdata[`CTRL_CIC];
			end
			if (wr_rsp) begin
				poll_response <= hwdata[7:0];
				rqs_reg       <= hwdata[`RSP_RQS];
			end else if (serial_polled) begin
				// request withdrawn once the controller has polled us
				rqs_reg <= 1'b0;
			end
			if (wr_mask1) begin
				mask1_reg <= hwdata[4:0];
			end
			if (wr_mask2) begin
				mask2_reg <= hwdata[2:0];
			end
		end
	end

	// service request drive only as device; open drain, line pulled low to assert
	assign srq_out = 1'b0;
	assign srq_oe  = rqs_reg && !cic_reg;

	// service request indication: one-shot until line drops or a poll completes
	reg  srq_prev_reg;
	reg  srq_ind_reg;
	reg  srq_armed_reg;
	wire poll_done;

	always @(posedge clock) begin
		if (srst) begin
			srq_prev_reg  <= 1'b0;
			srq_ind_reg   <= 1'b0;
			srq_armed_reg <= 1'b1;
		end else begin
			srq_prev_reg <= srq_line;
			if (srq_armed_reg && srq_line) begin
				srq_ind_reg   <= 1'b1;
				srq_armed_reg <= 1'b0;
			end else if (rd_bus && srq_ind_reg) begin
				srq_ind_reg <= 1'b0;
			end else if (poll_done || !srq_line) begin
				srq_armed_reg <= 1'b1;
			end
		end
	end

	// address status change detect
	reg talk_prev_reg;
	reg listen_prev_reg;
	always @(posedge clock) begin
		if (srst) begin
			talk_prev_reg   <= 1'b0;
			listen_prev_reg <= 1'b0;
		end else begin
			talk_prev_reg   <= talk_addressed_bit;
			listen_prev_reg <= listen_addressed_bit;
		end
	end
	wire address_change_flag = (talk_prev_reg != talk_addressed_bit) ||
		(listen_prev_reg != listen_addressed_bit);
	wire srq_rise = srq_line && !srq_prev_reg;

	// sticky flags, set wins over clear-on-read
	reg [4:0] stat1_reg;
	reg       stat2_service_request_seen_bit_reg;
	wire [4:0] set1;
	assign set1[`IS1_DI]   = byte_in_event;
	assign set1[`IS1_DO]   = byte_out_event;
	assign set1[`IS1_DEC]  = clear_rcvd && !cic_reg;
	assign set1[`IS1_DET]  = trigger_rcvd && !cic_reg;
	assign set1[`IS1_ADDR_CHG] = address_change_flag && !cic_reg;

	always @(posedge clock) begin
		if (srst) begin
			stat1_reg      <= 5'h00;
			stat2_service_request_seen_bit_reg <= 1'b0;
		end else begin
			stat1_reg      <= (rd_stat1 ? 5'h00 : stat1_reg) | set1;
			stat2_service_request_seen_bit_reg <= (rd_stat2 ? 1'b0 : stat2_service_request_seen_bit_reg) |
				(cic_reg && srq_rise);
		end
	end
	wire [2:0] stat2 = {stat2_service_request_seen_bit_reg, lockout_state, remote_state};

	// dma terminal count, clear on read
	reg [DMA_CHANNELS-1:0] tc_reg;
	always @(posedge clock) begin
		if (srst) begin
			tc_reg <= {DMA_CHANNELS{1'b0}};
		end else begin
			tc_reg <= (rd_dma ? {DMA_CHANNELS{1'b0}} : tc_reg) | dma_tc_event;
		end
	end
	// request held until acknowledged by the system dma controller
	assign dma_request_line = dma_want && !dma_ack;

	// interrupt: status two state bits count as flags while set
	assign irq = |(stat1_reg & mask1_reg) | |(stat2 & mask2_reg);

	// controller sequencer
	wire [7:0] result;
	wire       seq_busy;
	wire       seq_done;
	reg        ser_poll_seen_reg;

	poll_sequencer u_seq (
		.clock        (clock),
		.srst         (srst),
		.is_controller(cic_reg),
		.start_serial_poll_routine  (wr_cmd && hwdata[`CMD_SER_POLL]),
		.start_parallel_poll_routine  (wr_cmd && hwdata[`CMD_PAR_POLL]),
		.start_ppcfg  (wr_cmd && hwdata[`CMD_PPCFG]),
		.arg          (hwdata[7:0]),
		.cmd_valid    (cmd_valid),
		.cmd_byte     (cmd_byte),
		.cmd_ready    (cmd_ready),
		.serial_poll_routine_listen (serial_poll_routine_listen),
		.rx_valid     (rx_valid),
		.rx_byte      (rx_byte),
		.parallel_poll_routine_sample (parallel_poll_routine_sample),
		.dio_sync     (dio_sync),
		.result_reg   (result),
		.busy         (seq_busy),
		.done_pulse   (seq_done)
	);
	// only a completed serial poll re-arms the indicator, not a configure run
	assign poll_done = seq_done && ser_poll_seen_reg;

	always @(posedge clock) begin
		if (srst) begin
			ser_poll_seen_reg <= 1'b0;
		end else if (serial_poll_routine_listen) begin
			ser_poll_seen_reg <= 1'b1;
		end else if (seq_done) begin
			ser_poll_seen_reg <= 1'b0;
		end
	end

	// read mux, registered on the address phase edge
	always @(posedge clock) begin
		if (srst) begin
			hrdata <= 32'h00000000;
		end else if (take && !hwrite) begin
			case ({haddr[7:2], 2'b00})
				`ADDR_CTRL:      hrdata <= {31'h0, cic_reg};
				`ADDR_POLL_RSP:  hrdata <= {23'h0, rqs_reg, poll_response};
				`ADDR_RESULT:    hrdata <= {23'h0, seq_busy, result};
				`ADDR_IMASK1:    hrdata <= {27'h0, mask1_reg};
				`ADDR_IMASK2:    hrdata <= {29'h0, mask2_reg};
				`ADDR_ISTAT1:    hrdata <= {27'h0, stat1_reg};
				`ADDR_ISTAT2:    hrdata <= {29'h0, stat2};
				`ADDR_ADDR_STAT: hrdata <= {30'h0, listen_addressed_bit,
					talk_addressed_bit};
				`ADDR_DMA_STAT:  hrdata <= {{(32-DMA_CHANNELS){1'b0}}, tc_reg};
				`ADDR_BUS_STAT:  hrdata <= {31'h0, srq_ind_reg};
				default:         hrdata <= 32'h00000000;
			endcase
		end
	end
endmodule // poll_status
`default_nettype wire

// *** rtl/poll_status_regs.vh ***
// register map, field positions and command codes for the poll and status block
// assumes an AHB-Lite master with 32-bit single word transfers
//
// What this block does
// - status shows service-request indication: 1 once line asserts while armed, 0 after a read
// - a true service-request indication clears after one read, even if line stays
// - indication re-arms after a poll if line still asserted, else on next assertion
// - serial poll: talk address, enable, take one byte, disable, untalk
// - parallel poll starts only as active controller, samples eight data lines together
// - configure: listen address, configure command, then configuration byte; target stores it
// - as device, return host-programmed serial poll response byte when polled
// - writing the response byte may also assert the service-request line
// - host-writable mask bits let service request and bus events interrupt
// - as device, address change flag on talk or listen change; both bits readable
// - status one holds trigger and device clear received flags
// - status two shows remote and local lockout states
// - as controller, set service-request-seen bit once the line asserts
// - reading status one clears all its flags; reading status two clears only the service-request-seen bit
// - status one holds byte received and byte send ready flags
// - terminal count bit readable for each of three DMA channels
// - DMA uses request line answered by acknowledge from system controller
`ifndef POLL_STATUS_REGS_VH
`define POLL_STATUS_REGS_VH

// byte addresses
`define ADDR_CTRL      8'h00
`define ADDR_POLL_RSP  8'h04
`define ADDR_CMD       8'h08
`define ADDR_RESULT    8'h0C
`define ADDR_IMASK1    8'h10
`define ADDR_IMASK2    8'h14
`define ADDR_ISTAT1    8'h18
`define ADDR_ISTAT2    8'h1C
`define ADDR_ADDR_STAT 8'h20
`define ADDR_DMA_STAT  8'h24
`define ADDR_BUS_STAT  8'h28

// ctrl bits
`define CTRL_CIC       0
// serial_poll_routine_rsp: bits 7:0 byte, bit 8 request service
`define RSP_RQS        8
// cmd: bits 7:0 target/config, bit 8 start serial poll, bit 9 parallel poll,
// bit 10 configure
`define CMD_SER_POLL   8
`define CMD_PAR_POLL   9
`define CMD_PPCFG      10
// result: bits 7:0 byte, bit 8 busy
`define RES_BUSY       8

// status one fields
`define IS1_DI         0
`define IS1_DO         1
`define IS1_DEC        2
`define IS1_DET        3
`define IS1_ADDR_CHG   4
// status two fields
`define IS2_REM        0
`define IS2_LOK        1
`define IS2_SRQ_SEEN   2

// bus command codes
`define GPIB_TAG_TALK   8'h40
`define GPIB_TAG_LISTEN 8'h20
`define GPIB_UNT        8'h5F
`define GPIB_UNL        8'h3F
`define GPIB_SPE        8'h18
`define GPIB_SPD        8'h19
`define GPIB_PPC        8'h05

`define RST_BYTE        8'h00
`endif

// *** tb/bus_far_end.sv ***
// far side of the command port: bus engine plus the instrument being polled
// assumes the sequencer holds cmd_valid and cmd_byte until it sees cmd_ready
`default_nettype none
module bus_far_end #(
	parameter logic [7:0] RSP_BYTE = 8'hA5
) (
	// clock and pacing
	input  wire logic       clock,
	input  wire logic       slow,
	// command port
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_byte,
	output var  logic       cmd_ready,
	// poll response return
	input  wire logic       serial_poll_routine_listen,
	output var  logic       rx_valid,
	output var  logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] log_q[$];
	logic [1:0] pace_reg = 2'h0;
	initial begin
		cmd_ready = 1'b0;
		rx_valid  = 1'b0;
		rx_byte   = ~RSP_BYTE;
	end
	always @(posedge clock) begin
		pace_reg  <= (cmd_valid || serial_poll_routine_listen) ? pace_reg + 2'h1 : 2'h0;
		// slow pacing accepts only every fourth cycle to stretch the handshake
		cmd_ready <= cmd_valid && !cmd_ready && (!slow || pace_reg == 2'h3);
		if (cmd_valid && cmd_ready)
			log_q.push_back(cmd_byte);
		rx_valid  <= serial_poll_routine_listen && !rx_valid && pace_reg == 2'h3;
		// outside the strobe the byte lines flip every cycle, showing the response byte on alternate cycles
		rx_byte   <= (serial_poll_routine_listen && !rx_valid && pace_reg == 2'h3) ? RSP_BYTE : ~rx_byte;
	end
endmodule // bus_far_end
`default_nettype wire

// *** tb/poll_status_chk.sv ***
// concurrent checks on the poll and status block's command port, dma and response byte
// assumes it is bound into poll_status and sees that module's ports only
`default_nettype none
module poll_status_chk (
	// clock and reset
	input wire logic       clock,
	input wire logic       srst,
	// register bus
	input wire logic       hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	// command port
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic       cmd_ready,
	input wire logic       serial_poll_routine_listen,
	input wire logic       rx_valid,
	input wire logic       parallel_poll_routine_sample,
	// device side and dma
	input wire logic [7:0] poll_response,
	input wire logic       serial_polled,
	input wire logic       srq_oe,
	input wire logic       dma_want,
	input wire logic       dma_ack,
	input wire logic       dma_request_line
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	wire logic rsp_wr = hsel && hready && htrans[1] && hwrite && haddr == 8'h04;
	sequence spe_taken;
		cmd_valid && cmd_ready && cmd_byte == 8'h18;
	endsequence
	sequence byte_taken;
		serial_poll_routine_listen && rx_valid;
	endsequence
	sequence spd_taken;
		cmd_valid && cmd_ready && cmd_byte == 8'h19;
	endsequence
	a_spe_then_listen: assert property (spe_taken |-> ##[1:8] serial_poll_routine_listen)
		else $error("no listen after poll enable");
	a_byte_then_spd: assert property (byte_taken |-> ##[1:8] (cmd_valid && cmd_byte == 8'h19))
		else $error("no poll disable after response byte");
	a_spd_then_unt: assert property (spd_taken |-> ##[1:8] (cmd_valid && cmd_byte == 8'h5F))
		else $error("no untalk after poll disable");
	a_cmd_held: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_byte))
		else $error("command dropped before acceptance");
	a_parallel_poll_routine_pulse: assert property (parallel_poll_routine_sample |=> !parallel_poll_routine_sample)
		else $error("parallel poll strobe longer than one cycle");
	// the response byte moves only on the edge that ends a write's data phase
	a_rsp_stable: assert property (!$past(rsp_wr, 2) |-> $stable(poll_response))
		else $error("response byte changed without a write");
	a_srq_release: assert property (serial_polled |=> !srq_oe)
		else $error("service request held after serial poll");
	a_dma_gate: assert property (dma_request_line == (dma_want && !dma_ack))
		else $error("dma request not gated by acknowledge");
endmodule // poll_status_chk
bind poll_status poll_status_chk chk_u (.*);
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the poll and status block
// assumes poll_status, its header and bus_far_end are compiled alongside
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock, srst, hsel, hwrite, hready, hreadyout, hresp, slow;
	logic [7:0]  haddr, dio_in, cmd_byte, rx_byte, poll_response;
	logic [1:0]  htrans;
	logic [2:0]  hsize, dma_tc_event;
	logic [31:0] hwdata, hrdata, rd;
	logic        srq_in, srq_out, srq_oe, talk_addressed_bit, listen_addressed_bit;
	logic        remote_state, lockout_state, trigger_rcvd, clear_rcvd, byte_in_event;
	logic        byte_out_event, serial_polled, cmd_valid, cmd_ready, serial_poll_routine_listen;
	logic        rx_valid, parallel_poll_routine_sample, dma_want, dma_ack, dma_request_line, irq;
	int          err_total = 0;
	int          checks_done = 0;
	assign hready = hreadyout;
	poll_status dut_u (.*);
	bus_far_end far_u (
		.clock        (clock),
		.slow         (slow),
		.cmd_valid    (cmd_valid),
		.cmd_byte     (cmd_byte),
		.cmd_ready    (cmd_ready),
		.serial_poll_routine_listen (serial_poll_routine_listen),
		.rx_valid     (rx_valid),
		.rx_byte      (rx_byte)
	);
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		htrans <= 2'h2;
		hwrite <= wr;
		haddr  <= a;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask
	// busy may rise a cycle after the start lands, so give it time before polling
	task automatic wait_idle;
		tick(2);
		do ahb(1'b0, 8'h0C, 32'h0); while (rd[8] !== 1'b0);
	endtask
	task automatic t_regs;
		rdc("status1", 8'h18, 32'h0);
		rdc("unmapped", 8'h3C, 32'h0);
		ahb(1'b1, 8'h10, 32'h1F);
		rdc("mask1", 8'h10, 32'h1F);
		chk("hresp okay", hresp, 1'b0);
		$display("test regs done");
	endtask
	task automatic t_status1;
		@(posedge clock);
		{trigger_rcvd, clear_rcvd, byte_in_event, byte_out_event} <= 4'hF;
		talk_addressed_bit <= 1'b1;
		@(posedge clock);
		{trigger_rcvd, clear_rcvd, byte_in_event, byte_out_event} <= 4'h0;
		tick(2);
		chk("irq", irq, 1'b1);
		rdc("addr status", 8'h20, 32'h1);
		rdc("status1", 8'h18, 32'h1F);
		rdc("status1 again", 8'h18, 32'h0);
		chk("irq cleared", irq, 1'b0);
		ahb(1'b1, 8'h10, 32'h0);
		@(posedge clock);
		byte_in_event <= 1'b1;
		@(posedge clock);
		byte_in_event <= 1'b0;
		tick(2);
		chk("irq masked", irq, 1'b0);
		rdc("byte in", 8'h18, 32'h1);
		$display("test status1 done");
	endtask
	task automatic t_status2;
		@(posedge clock);
		{remote_state, lockout_state} <= 2'h3;
		tick(2);
		rdc("status2", 8'h1C, 32'h3);
		rdc("status2 live", 8'h1C, 32'h3);
		{remote_state, lockout_state} <= 2'h0;
		$display("test status2 done");
	endtask
	task automatic t_device;
		ahb(1'b1, 8'h04, 32'h1C3);
		tick(1);
		chk("response", poll_response, 8'hC3);
		chk("srq drive", srq_oe, 1'b1);
		chk("srq level", srq_out, 1'b0);
		serial_polled <= 1'b1;
		@(posedge clock);
		serial_polled <= 1'b0;
		tick(1);
		chk("srq release", srq_oe, 1'b0);
		chk("response kept", poll_response, 8'hC3);
		$display("test device done");
	endtask
	task automatic t_srq_poll;
		logic [7:0] exp_cmd[4] = '{8'h45, 8'h18, 8'h19, 8'h5F};
		ahb(1'b1, 8'h00, 32'h1);
		srq_in <= 1'b1;
		tick(4);
		rdc("srq", 8'h28, 32'h1);
		rdc("srq read twice", 8'h28, 32'h0);
		rdc("srq seen", 8'h1C, 32'h4);
		slow <= 1'b1;
		far_u.log_q.delete();
		ahb(1'b1, 8'h08, 32'h105);
		wait_idle;
		chk("poll byte", rd, 32'hA5);
		chk("poll cmds", far_u.log_q.size(), 32'h4);
		for (int i = 0; i < 4; i++)
			chk("poll cmd", far_u.log_q[i], exp_cmd[i]);
		rdc("srq rearmed", 8'h28, 32'h1);
		srq_in <= 1'b0;
		tick(4);
		rdc("srq low", 8'h28, 32'h0);
		srq_in <= 1'b1;
		tick(4);
		rdc("srq again", 8'h28, 32'h1);
		ahb(1'b1, 8'h14, 32'h4);
		tick(1);
		chk("irq srq", irq, 1'b1);
		rdc("srq seen again", 8'h1C, 32'h4);
		chk("irq srq cleared", irq, 1'b0);
		srq_in <= 1'b0;
		slow <= 1'b0;
		$display("test srq and serial poll done");
	endtask
	task automatic t_parallel_poll_routine;
		far_u.log_q.delete();
		ahb(1'b1, 8'h08, 32'h403);
		wait_idle;
		chk("cfg cmds", far_u.log_q.size(), 32'h4);
		chk("cfg listen", far_u.log_q[0][7:5], 3'h1);
		chk("cfg cmd", far_u.log_q[1], 8'h05);
		chk("cfg unlisten", far_u.log_q[3], 8'h3F);
		dio_in <= 8'h5A;
		tick(4);
		ahb(1'b1, 8'h08, 32'h200);
		wait_idle;
		chk("parallel_poll_routine", rd, 32'h5A);
		ahb(1'b1, 8'h08, 32'h200);
		wait_idle;
		chk("parallel_poll_routine kept", rd, 32'h5A);
		ahb(1'b1, 8'h00, 32'h0);
		dio_in <= 8'h81;
		tick(4);
		ahb(1'b1, 8'h08, 32'h200);
		tick(4);
		rdc("parallel_poll_routine refused", 8'h0C, 32'h5A);
		$display("test parallel poll done");
	endtask
	task automatic t_dma;
		@(posedge clock);
		dma_tc_event <= 3'h5;
		dma_want     <= 1'b1;
		@(posedge clock);
		dma_tc_event <= 3'h0;
		tick(1);
		chk("dma req", dma_request_line, 1'b1);
		dma_ack <= 1'b1;
		tick(1);
		chk("dma req acked", dma_request_line, 1'b0);
		rdc("dma tc", 8'h24, 32'h5);
		rdc("dma tc cleared", 8'h24, 32'h0);
		{dma_want, dma_ack} <= 2'h0;
		$display("test dma done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		{srst, hsel, hsize} = 5'h1A;
		{htrans, hwrite, haddr, hwdata, dio_in, dma_tc_event, slow} = '0;
		{srq_in, talk_addressed_bit, listen_addressed_bit, remote_state} = 4'h0;
		{lockout_state, trigger_rcvd, clear_rcvd, byte_in_event, byte_out_event} = 5'h0;
		{serial_polled, dma_want, dma_ack} = 3'h0;
		tick(8);
		srst <= 1'b0;
		t_regs;
		t_status1;
		t_status2;
		t_device;
		t_srq_poll;
		t_parallel_poll_routine;
		t_dma;
		tally_and_finish;
	end
	// about 46 transfers of three cycles each; 50 us leaves ample margin
	initial begin
		#50us;
		err_total++;
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
